// ==== rtl/bre_pkg.sv ====
// Constants and carrier types for the bridge error block.
// Assumes one bus clock and 16-bit configuration writes.
// Operation
// [RULE_01] Claim primary inside window, secondary outside.
// [RULE_02] No system error without command bit 8.
// [RULE_03] System error sets secondary status bit 14.
// [RULE_04] Error mask register resets to all zero.
// [RULE_05] Posted write parity error raises error, flag 1.
// [RULE_06] Posted write retry timeout raises error, flag 2.
// [RULE_07] Posted write target abort raises error, flag 3.
// [RULE_08] Posted write master abort raises error, flag 4.
// [RULE_09] Delayed write retry timeout raises error, flag 5.
// [RULE_10] Delayed read retry timeout raises error, flag 6.
// [RULE_11] Flags clear only by writing one.
// [RULE_12] Relay secondary error when command 8, control 1.
// [RULE_13] Forward data parity unchanged across buses.
// [RULE_14] Parity response: error on address parity, aborts.
// [RULE_15] Parity pin on response; status 15 always.
// [RULE_16] Status 8 on bad parity or master parity.
// [RULE_17] Write abort returns target abort.
// [RULE_18] Read abort: drain words, then disconnect.
// [RULE_19] Secondary reset: abort mode picks reporting.
// [RULE_20] Discard period 32768 clocks, 1024 with bit 9.
// [RULE_21] Discard entry when retry never comes.
// [RULE_22] May discard prefetchable reads early.
// [RULE_23] Retry matches only on address, command, enables.
// [RULE_24] Timer starts on completion, stops on retry.
// [RULE_25] Flags stay set until software clears them.
package bre_pkg;
   // Configuration offsets.
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h06;
   localparam logic [7:0] OFS_SSTAT = 8'h1E;
   localparam logic [7:0] OFS_BCTL = 8'h3E;
   localparam logic [7:0] OFS_MASK = 8'h64;
   localparam logic [7:0] OFS_FLAGS = 8'h6A;
   // Field positions.
   localparam int CMD_PAR_RESP = 6;
   localparam int CMD_SERR_EN = 8;
   localparam int STAT_DPE_MASTER = 8;
   localparam int STAT_DET_PAR = 15;
   localparam int SSTAT_SERR_SIG = 14;
   localparam int BCTL_SERR_FWD = 1;
   localparam int BCTL_MA_MODE = 5;
   localparam int BCTL_DISC_SHORT = 9;
   // Values after reset.
   localparam logic [15:0] RST_CMD = 16'h0000;
   localparam logic [15:0] RST_BCTL = 16'h0000;
   localparam logic [15:0] RST_STAT = 16'h0000;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_FLAGS = 8'h00;
   // Discard periods in bus clocks.
   localparam int DISC_SHORT_CLKS = 1024;
   localparam int DISC_LONG_CLKS = 32768;
   // Failure events; bit order matches flag bits 6..1.
   typedef struct packed {
      logic dr_timeout;
      logic dw_timeout;
      logic pw_mabort;
      logic pw_tabort;
      logic pw_timeout;
      logic pw_parity;
   } bre_err_ev_t;
   // Identity of a delayed request.
   typedef struct packed {
      logic [31:0] addr;
      logic [3:0] cmd;
      logic [3:0] be;
   } bre_req_t;
   // Configuration access.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] ofs;
      logic [1:0] be;
      logic [15:0] wdata;
   } bre_cfg_t;
   typedef enum {DT_IDLE, DT_PEND, DT_HELD} bre_dt_state_t;
endpackage : bre_pkg

// ==== rtl/bre_top.sv ====
// Error reporting, abort handling and discard timer.
// Assumes events arrive on clk_i.
// The secondary error pin is synchronised here.
`timescale 1ns/1ps
`default_nettype none
module bre_top #(
   parameter int DISC_LONG = bre_pkg::DISC_LONG_CLKS,
   parameter int DISC_SHORT = bre_pkg::DISC_SHORT_CLKS,
   parameter int RD_CNT_W = 8
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Configuration port.
   input wire bre_pkg::bre_cfg_t cfg_i,
   output logic [15:0] cfg_rdata_o,
   // Address decode.
   input wire logic pri_addr_valid_i,
   input wire logic [31:0] pri_addr_i,
   input wire logic sec_addr_valid_i,
   input wire logic [31:0] sec_addr_i,
   input wire logic [31:0] win_base_i,
   input wire logic [31:0] win_limit_i,
   output logic pri_claim_o,
   output logic sec_claim_o,
   // Error events.
   input wire bre_pkg::bre_err_ev_t err_ev_i,
   input wire logic addr_parity_err_i,
   input wire logic target_abort_seen_i,
   input wire logic sec_serr_n_i,
   input wire logic bad_data_parity_i,
   input wire logic master_perr_i,
   // Open-drain error pins.
   output logic upstream_system_error_pin_o,
   output logic upstream_system_error_pin_oe_n_o,
   output logic parity_error_pin_o,
   output logic parity_error_pin_oe_n_o,
   // Parity forwarding.
   input wire logic fwd_par_valid_i,
   input wire logic fwd_par_i,
   output logic fwd_par_o,
   // Burst abort handling.
   input wire logic write_burst_i,
   input wire logic read_burst_i,
   input wire logic dest_tabort_i,
   input wire logic rd_word_store_i,
   input wire logic rd_word_give_i,
   output logic init_tabort_o,
   output logic init_disconnect_o,
   // Access during secondary reset.
   input wire logic sec_rst_active_i,
   input wire logic pri_attempt_i,
   output logic pri_reset_tabort_o,
   output logic pri_reset_normal_o,
   // Delayed transaction tracking.
   input wire logic dt_req_i,
   input wire bre_pkg::bre_req_t req_i,
   input wire logic dt_done_i,
   input wire logic dt_prefetch_i,
   input wire logic dt_need_room_i,
   input wire logic retry_i,
   input wire bre_pkg::bre_req_t retry_req_i,
   output logic retry_accept_o,
   output logic retry_again_o,
   output logic dt_discard_o
);
   import bre_pkg::*;

   generate
      if (DISC_SHORT < 1 || DISC_LONG < DISC_SHORT || DISC_LONG > 65535) begin : g_bad_disc
         $error("Discard periods out of range.");
      end
      if (RD_CNT_W < 1) begin : g_bad_cnt
         $error("Read counter too narrow.");
      end
   endgenerate

   localparam logic [15:0] DISC_LONG_V = 16'(DISC_LONG - 1);
   localparam logic [15:0] DISC_SHORT_V = 16'(DISC_SHORT - 1);

   // Register contents.
   logic [15:0] cmd_reg;
   logic [15:0] bctl_reg;
   logic [15:0] stat_reg;
   logic [15:0] sstat_reg;
   logic [7:0] mask_reg;
   logic [7:0] flags_reg;

   // Decodes a halfword write to one offset.
   function automatic logic [15:0] wr_mask(input bre_cfg_t c, input logic [7:0] ofs);
      logic [15:0] m;
      m = 16'h0000;
      if (c.wr && c.ofs == ofs) begin
         m = {{8{c.be[1]}}, {8{c.be[0]}}};
      end
      return m;
   endfunction : wr_mask

   wire logic [15:0] cmd_we = wr_mask(cfg_i, OFS_CMD);
   wire logic [15:0] bctl_we = wr_mask(cfg_i, OFS_BCTL);
   wire logic [15:0] stat_we = wr_mask(cfg_i, OFS_STAT);
   wire logic [15:0] sstat_we = wr_mask(cfg_i, OFS_SSTAT);
   wire logic [15:0] mask_we = wr_mask(cfg_i, OFS_MASK);
   wire logic [15:0] flags_we = wr_mask(cfg_i, OFS_FLAGS);

   // Secondary error pin synchroniser.
   logic sec_serr_s1;
   logic sec_serr_s2;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sec_serr_s1 <= 1'b0;
         sec_serr_s2 <= 1'b0;
      end else begin
         sec_serr_s1 <= ~sec_serr_n_i;
         sec_serr_s2 <= sec_serr_s1;
      end
   end

   // Causes of a system error this cycle.
   logic [7:0] ev_vec;
   logic [7:0] ev_unmasked;
   logic serr_en;
   logic par_resp;
   logic serr_cause;
   logic next_serr;
   assign ev_vec = {1'b0, err_ev_i, 1'b0};
   assign ev_unmasked = ev_vec & ~mask_reg; // [RULE_05] [RULE_06] [RULE_07] [RULE_08] [RULE_09] [RULE_10]
   assign serr_en = cmd_reg[CMD_SERR_EN];
   assign par_resp = cmd_reg[CMD_PAR_RESP];
   assign serr_cause = (|ev_unmasked)
      | (par_resp & (addr_parity_err_i | target_abort_seen_i)) // [RULE_14]
      | (bctl_reg[BCTL_SERR_FWD] & sec_serr_s2); // [RULE_12]
   assign next_serr = serr_en & serr_cause; // [RULE_02]

   // System error pin: low one clock per cycle with any cause.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         upstream_system_error_pin_o <= 1'b1;
         upstream_system_error_pin_oe_n_o <= 1'b1;
      end else begin
         upstream_system_error_pin_o <= ~next_serr;
         upstream_system_error_pin_oe_n_o <= ~next_serr; // [RULE_02]
      end
   end

   // Parity error pin: low one clock after bad data.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         parity_error_pin_o <= 1'b1;
         parity_error_pin_oe_n_o <= 1'b1;
      end else begin
         parity_error_pin_o <= ~(par_resp & bad_data_parity_i);
         parity_error_pin_oe_n_o <= ~(par_resp & bad_data_parity_i); // [RULE_15]
      end
   end

   // Command and bridge control: plain read-write.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cmd_reg <= RST_CMD;
         bctl_reg <= RST_BCTL;
      end else begin
         cmd_reg <= (cmd_reg & ~cmd_we) | (cfg_i.wdata & cmd_we);
         bctl_reg <= (bctl_reg & ~bctl_we) | (cfg_i.wdata & bctl_we);
      end
   end

   // Mask: every condition reports after reset.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mask_reg <= RST_MASK; // [RULE_04]
      end else begin
         mask_reg <= (mask_reg & ~mask_we[7:0]) | (cfg_i.wdata[7:0] & mask_we[7:0]);
      end
   end

   // Flags: set by enabled events, cleared by writing one.
   // A new event in the clearing cycle keeps its flag.
   wire logic [7:0] flag_set = serr_en ? ev_unmasked : 8'h00;
   wire logic [7:0] flag_clr = cfg_i.wdata[7:0] & flags_we[7:0];
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flags_reg <= RST_FLAGS;
      end else begin
         flags_reg <= (flags_reg & ~flag_clr) | flag_set; // [RULE_11] [RULE_25]
      end
   end

   // Status bits, write one to clear, set wins over clear.
   logic [15:0] stat_set;
   logic [15:0] sstat_set;
   always_comb begin
      stat_set = 16'h0000;
      stat_set[STAT_DET_PAR] = bad_data_parity_i; // [RULE_15]
      stat_set[STAT_DPE_MASTER] = par_resp & (bad_data_parity_i | master_perr_i); // [RULE_16]
      sstat_set = 16'h0000;
      sstat_set[SSTAT_SERR_SIG] = next_serr; // [RULE_03]
   end
   wire logic [15:0] stat_clr = cfg_i.wdata & stat_we;
   wire logic [15:0] sstat_clr = cfg_i.wdata & sstat_we;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stat_reg <= RST_STAT;
         sstat_reg <= RST_STAT;
      end else begin
         stat_reg <= (stat_reg & ~stat_clr) | stat_set;
         sstat_reg <= (sstat_reg & ~sstat_clr) | sstat_set;
      end
   end

   // Read data; unmapped offsets read zero.
   logic [15:0] next_rdata;
   always_comb begin
      case (cfg_i.ofs)
         OFS_CMD: next_rdata = cmd_reg;
         OFS_STAT: next_rdata = stat_reg;
         OFS_SSTAT: next_rdata = sstat_reg;
         OFS_BCTL: next_rdata = bctl_reg;
         OFS_MASK: next_rdata = {8'h00, mask_reg};
         OFS_FLAGS: next_rdata = {8'h00, flags_reg};
         default: next_rdata = 16'h0000;
      endcase
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_rdata_o <= 16'h0000;
      end else if (cfg_i.rd) begin
         cfg_rdata_o <= next_rdata;
      end
   end

   // Positive decode upstream, negative decode downstream.
   wire logic pri_in = (pri_addr_i >= win_base_i) && (pri_addr_i <= win_limit_i);
   wire logic sec_in = (sec_addr_i >= win_base_i) && (sec_addr_i <= win_limit_i);
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pri_claim_o <= 1'b0;
         sec_claim_o <= 1'b0;
      end else begin
         pri_claim_o <= pri_addr_valid_i & pri_in; // [RULE_01]
         sec_claim_o <= sec_addr_valid_i & ~sec_in; // [RULE_01]
      end
   end

   // Parity copied untouched, one clock behind.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fwd_par_o <= 1'b0;
      end else if (fwd_par_valid_i) begin
         fwd_par_o <= fwd_par_i; // [RULE_13]
      end
   end

   // Read words fetched but not yet delivered.
   logic [RD_CNT_W-1:0] rd_cnt;
   logic rd_abort_pend;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_cnt <= '0;
      end else if (rd_word_store_i && !rd_word_give_i) begin
         rd_cnt <= rd_cnt + 1'b1;
      end else if (rd_word_give_i && !rd_word_store_i && rd_cnt != '0) begin
         rd_cnt <= rd_cnt - 1'b1;
      end
   end

   // Write aborts echo at once; read aborts wait for the drain.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         init_tabort_o <= 1'b0;
         init_disconnect_o <= 1'b0;
         rd_abort_pend <= 1'b0;
      end else begin
         init_tabort_o <= write_burst_i & dest_tabort_i; // [RULE_17]
         init_disconnect_o <= 1'b0;
         if (read_burst_i && dest_tabort_i) begin
            rd_abort_pend <= 1'b1;
         end else if (rd_abort_pend && rd_cnt == '0) begin
            rd_abort_pend <= 1'b0;
            init_disconnect_o <= 1'b1; // [RULE_18]
         end
      end
   end

   // Primary access during secondary reset.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pri_reset_tabort_o <= 1'b0;
         pri_reset_normal_o <= 1'b0;
      end else begin
         pri_reset_tabort_o <= pri_attempt_i & sec_rst_active_i & bctl_reg[BCTL_MA_MODE]; // [RULE_19]
         pri_reset_normal_o <= pri_attempt_i & sec_rst_active_i & ~bctl_reg[BCTL_MA_MODE]; // [RULE_19]
      end
   end

   // Delayed entry: latch, completion, retry, discard.
   bre_dt_state_t dt_state;
   bre_req_t dt_latched;
   logic [15:0] dt_timer;
   wire logic dt_match = (retry_req_i == dt_latched); // [RULE_23]
   wire logic dt_expired = (dt_timer == 16'h0000);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dt_latched <= '0;
      end else if (dt_req_i && dt_state == DT_IDLE) begin
         dt_latched <= req_i;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dt_state <= DT_IDLE;
         dt_timer <= 16'h0000;
         retry_accept_o <= 1'b0;
         retry_again_o <= 1'b0;
         dt_discard_o <= 1'b0;
      end else begin
         retry_accept_o <= 1'b0;
         retry_again_o <= 1'b0;
         dt_discard_o <= 1'b0;
         case (dt_state)
            DT_IDLE: begin
               if (dt_req_i) begin
                  dt_state <= DT_PEND;
               end
            end
            DT_PEND: begin
               if (retry_i) begin
                  retry_again_o <= 1'b1;
               end
               if (dt_done_i) begin
                  dt_state <= DT_HELD;
                  dt_timer <= bctl_reg[BCTL_DISC_SHORT] ? DISC_SHORT_V : DISC_LONG_V; // [RULE_20] [RULE_24]
               end
            end
            DT_HELD: begin
               if (retry_i && dt_match) begin
                  retry_accept_o <= 1'b1;
                  dt_state <= DT_IDLE; // [RULE_24]
               end else if (dt_expired || (dt_prefetch_i && dt_need_room_i)) begin
                  dt_discard_o <= 1'b1; // [RULE_21] [RULE_22]
                  dt_state <= DT_IDLE;
               end else begin
                  retry_again_o <= retry_i; // [RULE_23]
                  dt_timer <= dt_timer - 16'h0001;
               end
            end
            default: begin
               dt_state <= DT_IDLE;
            end
         endcase
      end
   end
endmodule : bre_top
`default_nettype wire

// ==== verification/bre_properties.sv ====
// Checker on the bridge error block's top-level ports.
// Assumes one bus clock and the active-low reset.
`timescale 1ns/1ps
`default_nettype none
module bre_properties (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Address decode.
   input wire logic pri_addr_valid_i,
   input wire logic [31:0] pri_addr_i,
   input wire logic sec_addr_valid_i,
   input wire logic [31:0] sec_addr_i,
   input wire logic [31:0] win_base_i,
   input wire logic [31:0] win_limit_i,
   input wire logic pri_claim_o,
   input wire logic sec_claim_o,
   // Error reporting.
   input wire bre_pkg::bre_err_ev_t err_ev_i,
   input wire logic addr_parity_err_i,
   input wire logic target_abort_seen_i,
   input wire logic sec_serr_n_i,
   input wire logic bad_data_parity_i,
   input wire logic upstream_system_error_pin_oe_n_o,
   input wire logic parity_error_pin_oe_n_o,
   // Parity forwarding and aborts.
   input wire logic fwd_par_valid_i,
   input wire logic fwd_par_i,
   input wire logic fwd_par_o,
   input wire logic write_burst_i,
   input wire logic read_burst_i,
   input wire logic dest_tabort_i,
   input wire logic init_tabort_o,
   input wire logic init_disconnect_o,
   input wire logic sec_rst_active_i,
   input wire logic pri_attempt_i,
   input wire logic pri_reset_tabort_o,
   input wire logic pri_reset_normal_o
);
   import bre_pkg::*;
   // One clock and one reset for every check.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // The system error pin needs a recent cause.
   property upstream_system_error_pin_cause;
      !upstream_system_error_pin_oe_n_o |-> (|$past(err_ev_i)) || $past(addr_parity_err_i)
         || $past(target_abort_seen_i) || !$past(sec_serr_n_i, 3) || !$past(sec_serr_n_i, 4);
   endproperty
   a_serr_cause: assert property (upstream_system_error_pin_cause) else $error("system error pin without cause");
   // Primary claims inside the window.
   property p_pri_claim;
      pri_addr_valid_i |=> pri_claim_o == ($past(pri_addr_i) >= $past(win_base_i)
         && $past(pri_addr_i) <= $past(win_limit_i));
   endproperty
   a_pri_claim: assert property (p_pri_claim) else $error("primary claim wrong");
   // Secondary claims outside the window.
   property p_sec_claim;
      sec_addr_valid_i |=> sec_claim_o == ($past(sec_addr_i) < $past(win_base_i)
         || $past(sec_addr_i) > $past(win_limit_i));
   endproperty
   a_sec_claim: assert property (p_sec_claim) else $error("secondary claim wrong");
   // The parity pin follows bad data.
   property p_par_pin;
      !parity_error_pin_oe_n_o |-> $past(bad_data_parity_i);
   endproperty
   a_par_pin: assert property (p_par_pin) else $error("parity pin without cause");
   // A write abort is echoed next cycle.
   property p_wr_abort;
      write_burst_i && dest_tabort_i |=> init_tabort_o;
   endproperty
   a_wr_abort: assert property (p_wr_abort) else $error("write abort not returned");
   // A read abort never disconnects at once.
   property p_rd_abort;
      read_burst_i && dest_tabort_i |=> !init_disconnect_o;
   endproperty
   a_rd_abort: assert property (p_rd_abort) else $error("early read disconnect");
   // Forwarded parity is copied unchanged.
   property p_fwd_par;
      fwd_par_valid_i |=> fwd_par_o == $past(fwd_par_i);
   endproperty
   a_fwd_par: assert property (p_fwd_par) else $error("forwarded parity changed");
   // A reset-time attempt gets one answer.
   property p_rst_mode;
      pri_attempt_i && sec_rst_active_i |=> pri_reset_tabort_o ^ pri_reset_normal_o;
   endproperty
   a_rst_mode: assert property (p_rst_mode) else $error("reset answer wrong");
endmodule : bre_properties
`default_nettype wire

// ==== verification/bre_far_model.sv ====
// Far side: secondary error pin and retrying initiator.
// Drives its lines at the falling bench clock edge.
`timescale 1ns/1ps
`default_nettype none
module bre_far_model (
   // Clock.
   input wire logic clk_i,
   // Far-side lines.
   output logic sec_serr_n_o,
   output logic retry_o,
   output bre_pkg::bre_req_t retry_req_o
);
   import bre_pkg::*;
   // The error pin has a pull-up, so it idles high.
   initial begin
      sec_serr_n_o = 1'b1;
      retry_o = 1'b0;
      retry_req_o = '0;
   end
   // Holds the secondary error pin low for n cycles.
   task automatic serr(input int n);
      @(negedge clk_i);
      sec_serr_n_o = 1'b0;
      repeat (n) @(negedge clk_i);
      sec_serr_n_o = 1'b1;
   endtask : serr
   // Retries with identity r; released lines show its inverse.
   task automatic retry(input bre_req_t r);
      @(negedge clk_i);
      retry_o = 1'b1;
      retry_req_o = r;
      @(negedge clk_i);
      retry_o = 1'b0;
      retry_req_o = ~r;
   endtask : retry
endmodule : bre_far_model
`default_nettype wire

// ==== verification/tb.sv ====
// Bench for the bridge error block and far-side model.
// Assumes short discard periods; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import bre_pkg::*;
   localparam int LONG_N = 64;
   localparam int SHORT_N = 16;
   localparam logic [15:0] APAR = 16'h0001, TAS = 16'h0002, BDP = 16'h0004, MPERR = 16'h0008;
   localparam logic [15:0] DTA = 16'h0010, STORE = 16'h0020, GIVE = 16'h0040, ATT = 16'h0080;
   localparam logic [15:0] REQ = 16'h0100, DONE = 16'h0200, EV0 = 16'h0400;
   logic clk_i, arst_n_i, pri_addr_valid_i, sec_addr_valid_i, addr_parity_err_i, target_abort_seen_i;
   logic sec_serr_n_i, bad_data_parity_i, master_perr_i, fwd_par_valid_i, fwd_par_i, write_burst_i;
   logic read_burst_i, dest_tabort_i, rd_word_store_i, rd_word_give_i, sec_rst_active_i, pri_attempt_i;
   logic dt_req_i, dt_done_i, dt_prefetch_i, dt_need_room_i, retry_i;
   logic [31:0] pri_addr_i, sec_addr_i, win_base_i, win_limit_i;
   bre_cfg_t cfg_i;
   bre_err_ev_t err_ev_i;
   bre_req_t req_i, retry_req_i;
   logic [15:0] cfg_rdata_o, pv;
   logic pri_claim_o, sec_claim_o, upstream_system_error_pin_o, upstream_system_error_pin_oe_n_o;
   logic parity_error_pin_o, parity_error_pin_oe_n_o, fwd_par_o, init_tabort_o, init_disconnect_o;
   logic pri_reset_tabort_o, pri_reset_normal_o, retry_accept_o, retry_again_o, dt_discard_o;
   int bad_count = 0, compares = 0;
   logic [31:0] addr_tab [4] = '{32'h0000_0FFF, 32'h0000_1000, 32'h0000_1FFF, 32'h0000_2000};
   logic [1:0] claim_tab [4] = '{2'h1, 2'h2, 2'h2, 2'h1};
   logic [7:0] ofs_tab [7] = '{OFS_CMD, OFS_STAT, OFS_SSTAT, OFS_BCTL, OFS_MASK, OFS_FLAGS, 8'h40};
   // One-cycle event pulses come from one vector.
   assign {err_ev_i, dt_done_i, dt_req_i, pri_attempt_i, rd_word_give_i, rd_word_store_i, dest_tabort_i,
      master_perr_i, bad_data_parity_i, target_abort_seen_i, addr_parity_err_i} = pv;
   // Device and far side.
   bre_top #(.DISC_LONG(LONG_N), .DISC_SHORT(SHORT_N)) bre_top_i (.*);
   bre_far_model bre_far_model_i (.clk_i(clk_i), .sec_serr_n_o(sec_serr_n_i), .retry_o(retry_i),
      .retry_req_o(retry_req_i));
   // Bus clock at 10 MHz.
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask : tick
   // Compares seen with expected.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Configuration write, or read compared with d.
   task automatic cfg(input logic w, input logic [7:0] ofs, input logic [15:0] d);
      tick(1);
      cfg_i = '{wr: w, rd: !w, ofs: ofs, be: 2'h3, wdata: d};
      tick(1);
      cfg_i = '0;
      if (!w) begin
         tick(1);
         check(cfg_rdata_o, d);
      end
   endtask : cfg
   task automatic pulse(input logic [15:0] m);
      tick(1);
      pv = m;
      tick(1);
      pv = '0;
   endtask : pulse
   task automatic watch(input int n, output int lows);
      lows = 0;
      repeat (n) begin
         tick(1);
         lows += int'(upstream_system_error_pin_oe_n_o === 1'b0);
      end
   endtask : watch
   task automatic complete_run();
      $display("compares %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run
   // Cuts a hang short.
   initial begin
      tick(20000);
      bad_count++;
      complete_run();
   end
   // Main sequence.
   initial begin
      int k;
      {pri_addr_valid_i, sec_addr_valid_i, fwd_par_valid_i, fwd_par_i, write_burst_i, read_burst_i} = '0;
      {sec_rst_active_i, dt_prefetch_i, dt_need_room_i, pri_addr_i, sec_addr_i} = '0;
      win_base_i = 32'h0000_1000;
      win_limit_i = 32'h0000_1FFF;
      cfg_i = '0;
      pv = '0;
      req_i = '{addr: 32'h0000_2040, cmd: 4'h6, be: 4'h0};
      arst_n_i = 1'b0;
      tick(6);
      arst_n_i = 1'b1;
      cfg(1'b1, 8'h40, 16'hFFFF);
      foreach (ofs_tab[i]) cfg(1'b0, ofs_tab[i], 16'h0000);
      pulse(EV0);
      check(upstream_system_error_pin_oe_n_o, 1'b1);
      // Each failure event raises the pin and its sticky flag.
      cfg(1'b1, OFS_CMD, 16'h0140);
      for (int i = 0; i < 6; i++) begin
         pulse(EV0 << i);
         check({upstream_system_error_pin_o, upstream_system_error_pin_oe_n_o}, 2'h0);
         pulse(EV0 << i);
         cfg(1'b1, OFS_FLAGS, ~(16'h0002 << i));
         cfg(1'b0, OFS_FLAGS, 16'h0002 << i);
         cfg(1'b1, OFS_FLAGS, 16'h0002 << i);
         cfg(1'b0, OFS_FLAGS, 16'h0000);
      end
      cfg(1'b0, OFS_SSTAT, 16'h4000);
      cfg(1'b1, OFS_MASK, 16'h007E);
      pulse(16'hFC00);
      check(upstream_system_error_pin_oe_n_o, 1'b1);
      cfg(1'b1, OFS_MASK, 16'h0000);
      pulse(APAR);
      check(upstream_system_error_pin_oe_n_o, 1'b0);
      pulse(TAS);
      check(upstream_system_error_pin_oe_n_o, 1'b0);
      cfg(1'b1, OFS_CMD, 16'h0100);
      pulse(APAR | TAS);
      check(upstream_system_error_pin_oe_n_o, 1'b1);
      // Secondary error relay needs both enables.
      for (int i = 0; i < 3; i++) begin
         cfg(1'b1, OFS_CMD, i == 1 ? 16'h0000 : 16'h0100);
         cfg(1'b1, OFS_BCTL, i == 0 ? 16'h0000 : 16'h0002);
         fork
            bre_far_model_i.serr(4);
            watch(12, k);
         join
         check(k, i == 2 ? 4 : 0);
      end
      // Data parity status and pin.
      cfg(1'b1, OFS_CMD, 16'h0040);
      pulse(BDP);
      check({parity_error_pin_o, parity_error_pin_oe_n_o}, 2'h0);
      cfg(1'b0, OFS_STAT, 16'h8100);
      cfg(1'b1, OFS_STAT, 16'hFFFF);
      pulse(MPERR);
      cfg(1'b0, OFS_STAT, 16'h0100);
      cfg(1'b1, OFS_STAT, 16'hFFFF);
      cfg(1'b1, OFS_CMD, 16'h0000);
      pulse(BDP | MPERR);
      check(parity_error_pin_oe_n_o, 1'b1);
      cfg(1'b0, OFS_STAT, 16'h8000);
      // Window edges, then parity forwarding.
      for (int i = 0; i < 4; i++) begin
         tick(1);
         {pri_addr_i, sec_addr_i, pri_addr_valid_i, sec_addr_valid_i} = {addr_tab[i], addr_tab[i], 2'h3};
         tick(1);
         {pri_addr_valid_i, sec_addr_valid_i, fwd_par_valid_i, fwd_par_i} = {2'h0, 1'b1, i[0]};
         check({pri_claim_o, sec_claim_o}, claim_tab[i]);
         tick(1);
         {fwd_par_valid_i, fwd_par_i} = {1'b0, !i[0]};
         tick(1);
         check(fwd_par_o, i[0]);
      end
      // Aborts on write and read bursts, then primary access during secondary reset.
      write_burst_i = 1'b1;
      pulse(DTA);
      check(init_tabort_o, 1'b1);
      {write_burst_i, read_burst_i} = 2'h1;
      pulse(STORE);
      pulse(STORE);
      pulse(DTA);
      pulse(GIVE);
      pulse(GIVE);
      check(init_disconnect_o, 1'b0);
      tick(1);
      check(init_disconnect_o, 1'b1);
      {read_burst_i, sec_rst_active_i} = 2'h1;
      for (int i = 0; i < 2; i++) begin
         cfg(1'b1, OFS_BCTL, i ? 16'h0020 : 16'h0000);
         pulse(ATT);
         check({pri_reset_tabort_o, pri_reset_normal_o}, i ? 2'h2 : 2'h1);
      end
      sec_rst_active_i = 1'b0;
      // Delayed entry: retry matching, then discard timing.
      for (int i = 0; i < 2; i++) begin
         cfg(1'b1, OFS_BCTL, i ? 16'h0000 : 16'h0200);
         pulse(REQ);
         bre_far_model_i.retry(req_i);
         check(retry_again_o, 1'b1);
         pulse(DONE);
         bre_far_model_i.retry('{addr: req_i.addr, cmd: req_i.cmd, be: 4'hF});
         check(retry_again_o, 1'b1);
         bre_far_model_i.retry(req_i);
         check(retry_accept_o, 1'b1);
         k = 0;
         repeat (LONG_N + 4) begin
            tick(1);
            k += int'(dt_discard_o === 1'b1);
         end
         check(k, 0);
         pulse(REQ);
         pulse(DONE);
         k = 1;
         while (dt_discard_o !== 1'b1 && k < 200) begin
            tick(1);
            k++;
         end
         check(k, (i ? LONG_N : SHORT_N) + 1);
      end
      pulse(REQ);
      pulse(DONE);
      {dt_prefetch_i, dt_need_room_i} = 2'h3;
      tick(1);
      check(dt_discard_o, 1'b1);
      {dt_prefetch_i, dt_need_room_i} = 2'h0;
      complete_run();
   end
endmodule : tb
bind bre_top bre_properties bre_properties_i (.*);
`default_nettype wire
